// [logic/wwdr_device.sv]
// windowed watchdog register bank and counting logic
`timescale 1ns/10ps
module wwdr_device
    import wwdr_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_n_i,
    wwdr_bus_if.device bus,
    output logic chip_reset_o,
    output logic warning_o,
    output logic clock_lock_o
);

    typedef struct packed {
        logic run;
        logic rst_en;
        logic tof;
        logic wflag;
        logic prot;
        logic act_run;
        logic act_rst;
        logic act_prot;
        logic [23:0] reload;
        logic [23:0] window;
        logic [23:0] counter;
        logic [23:0] readout;
        logic [9:0] warn;
        logic armed;
        logic [6:0] div;
        logic [1:0] pre;
        logic ack;
        logic [31:0] rdata;
        logic chip_reset;
    } wwdr_dev_state_t;

    wwdr_dev_state_t state_reg;
    wwdr_dev_state_t state_next;

    ////////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        logic tick;
        logic ev_timeout;
        logic ev_feed_err;
        logic ev_window;
        logic ev_protect;
        logic warn_match;
        logic is_feed2;
        logic feed_ok;
        tick = 1'b0;
        ev_timeout = 1'b0;
        ev_feed_err = 1'b0;
        ev_window = 1'b0;
        ev_protect = 1'b0;
        warn_match = 1'b0;
        is_feed2 = 1'b0;
        feed_ok = 1'b0;
        state_next = state_reg;
        state_next.ack = 1'b0;
        state_next.chip_reset = 1'b0;

        // count clock enable, then fixed divide by four
        if (state_reg.div == DIV_LAST)
        begin
            state_next.div = '0;
            if (state_reg.pre == PRESCALE_LAST)
            begin
                state_next.pre = '0;
                tick = 1'b1;
            end
            else
            begin
                state_next.pre = state_reg.pre + 2'h1;
            end
        end
        else
        begin
            state_next.div = state_reg.div + 7'h01;
        end

        // readout is a snapshot taken on the count tick, so reads lag the counter
        if (tick)
        begin
            state_next.readout = state_reg.counter;
        end

        // counting uses the active copy of the mode, not the bus view
        if (tick && state_reg.act_run)
        begin
            if (state_reg.counter != '0)
            begin
                state_next.counter = state_reg.counter - COUNT_ONE;
                if (state_reg.counter == COUNT_ONE)
                begin
                    ev_timeout = 1'b1;
                end
            end
            if (state_reg.counter[23:10] == COUNT_HIGH_ZERO &&
                state_reg.counter[9:0] == state_reg.warn)
            begin
                warn_match = 1'b1;
            end
        end

        ////////////////////////////////////////////////////////////////////////////////
        // register access: one cycle, ack registered
        if (bus.req)
        begin
            state_next.ack = 1'b1;
            state_next.rdata = '0;
            is_feed2 = bus.we && bus.addr == OFS_FEED && bus.wdata[7:0] == FEED_SECOND;
            if (state_reg.armed && !is_feed2)
            begin
                // feed errors are ignored until a first valid feed started the count
                ev_feed_err = state_reg.act_run;
                state_next.armed = 1'b0;
            end
            if (bus.we)
            begin
                if (bus.addr == OFS_MODE)
                begin
                    state_next.run = state_reg.run | bus.wdata[BIT_RUN];
                    state_next.rst_en = state_reg.rst_en | bus.wdata[BIT_RST];
                    state_next.prot = state_reg.prot | bus.wdata[BIT_PROT];
                    if (!bus.wdata[BIT_TOF])
                    begin
                        state_next.tof = 1'b0;
                    end
                    if (bus.wdata[BIT_WFLAG])
                    begin
                        state_next.wflag = 1'b0;
                    end
                end
                else if (bus.addr == OFS_RELOAD)
                begin
                    if (state_reg.act_prot && !(state_reg.counter < 24'(state_reg.warn) &&
                        state_reg.counter < state_reg.window))
                    begin
                        ev_protect = 1'b1;
                    end
                    else if (bus.wdata[23:0] < RELOAD_MIN)
                    begin
                        state_next.reload = RELOAD_MIN;
                    end
                    else
                    begin
                        state_next.reload = bus.wdata[23:0];
                    end
                end
                else if (bus.addr == OFS_FEED)
                begin
                    if (bus.wdata[7:0] == FEED_FIRST && !state_reg.armed)
                    begin
                        state_next.armed = 1'b1;
                    end
                    else if (is_feed2 && state_reg.armed)
                    begin
                        feed_ok = 1'b1;
                    end
                end
                else if (bus.addr == OFS_WARN)
                begin
                    state_next.warn = bus.wdata[9:0];
                end
                else if (bus.addr == OFS_WINDOW)
                begin
                    state_next.window = bus.wdata[23:0];
                end
            end
            else
            begin
                if (bus.addr == OFS_MODE)
                begin
                    state_next.rdata[BIT_RUN] = state_reg.run;
                    state_next.rdata[BIT_RST] = state_reg.rst_en;
                    state_next.rdata[BIT_TOF] = state_reg.tof;
                    state_next.rdata[BIT_WFLAG] = state_reg.wflag;
                    state_next.rdata[BIT_PROT] = state_reg.prot;
                end
                else if (bus.addr == OFS_RELOAD)
                begin
                    state_next.rdata[23:0] = state_reg.reload;
                end
                else if (bus.addr == OFS_COUNT)
                begin
                    state_next.rdata[23:0] = state_reg.readout;
                end
                else if (bus.addr == OFS_WARN)
                begin
                    state_next.rdata[9:0] = state_reg.warn;
                end
                else if (bus.addr == OFS_WINDOW)
                begin
                    state_next.rdata[23:0] = state_reg.window;
                end
                // feed register and unmapped offsets read as zero
            end
        end

        ////////////////////////////////////////////////////////////////////////////////
        // a completed feed reloads and makes the written mode active
        if (feed_ok)
        begin
            state_next.armed = 1'b0;
            state_next.counter = state_reg.reload;
            state_next.act_run = state_reg.run;
            state_next.act_rst = state_reg.rst_en;
            state_next.act_prot = state_reg.prot;
            if (state_reg.act_run && state_reg.counter > state_reg.window)
            begin
                ev_window = 1'b1;
            end
        end

        // hardware set comes after the software clear, so the set wins
        if (ev_timeout || ev_feed_err || ev_window || ev_protect)
        begin
            state_next.tof = 1'b1;
            state_next.chip_reset = state_reg.act_rst;
        end
        if (warn_match)
        begin
            state_next.wflag = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register; the chip reset pulse does not clear the flag
    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            state_reg <= '0;
            state_reg.reload <= RELOAD_RST;
            state_reg.window <= WINDOW_RST;
            state_reg.counter <= COUNT_RST;
            state_reg.readout <= COUNT_RST;
            state_reg.warn <= WARN_RST;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign bus.ack = state_reg.ack;
    assign bus.rdata = state_reg.rdata;
    assign chip_reset_o = state_reg.chip_reset;
    assign warning_o = state_reg.wflag;
    assign clock_lock_o = state_reg.run;

endmodule

// [logic/wwdr_pkg.sv]
// constants and types shared by the watchdog register block and its controller
// How it works
// - feed writes 0xAA then 0x55, reloads counter
// - mode changes act only after next feed
// - run enable bit 0, set only
// - running locks the counting clock source
// - controller picks clock source before run
// - reset enable bit 1, set only, gates reset
// - timeout flag bit 2, sticky until cleared
// - flag set gives reset; mode write with bit 2 zero clears
// - warning flag bit 3 sticky on match
// - protect bit 4 restricts reload writes
// - protect only together with reset enable
// - reload at 0x004, resets to 0xFF
// - counter readout at 0x00C, resets 0xFF
// - feed at 0x008 write only, reads zero
// - warning 0x014 reset 0, window 0x018
// - controller writes zero to mode bits 31:5
// - counter decrements every four count clocks
// - wrong access after 0xAA is feed error
// - feed above window is watchdog event
// - warning match: low ten bits, upper zero
package wwdr_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // device register map
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_RELOAD = 8'h04;
    localparam logic [7:0] OFS_FEED = 8'h08;
    localparam logic [7:0] OFS_COUNT = 8'h0C;
    localparam logic [7:0] OFS_WARN = 8'h14;
    localparam logic [7:0] OFS_WINDOW = 8'h18;

    localparam int BIT_RUN = 0;
    localparam int BIT_RST = 1;
    localparam int BIT_TOF = 2;
    localparam int BIT_WFLAG = 3;
    localparam int BIT_PROT = 4;
    localparam logic [31:0] MODE_MASK = 32'h0000001F;

    localparam logic [7:0] FEED_FIRST = 8'hAA;
    localparam logic [7:0] FEED_SECOND = 8'h55;

    localparam logic [23:0] RELOAD_RST = 24'h0000FF;
    localparam logic [23:0] RELOAD_MIN = 24'h0000FF;
    localparam logic [23:0] COUNT_RST = 24'h0000FF;
    localparam logic [23:0] COUNT_ONE = 24'h000001;
    localparam logic [9:0] WARN_RST = 10'h000;
    localparam logic [23:0] WINDOW_RST = 24'hFFFFFF;
    localparam logic [13:0] COUNT_HIGH_ZERO = 14'h0000;

    ////////////////////////////////////////////////////////////////////////////////
    // timing: count clock is an enable pulse, then a divide-by-four prescaler
    localparam int CLK_HZ = 50_000_000;
    localparam int COUNT_CLK_HZ = 500_000;
    localparam int COUNT_DIV = CLK_HZ / COUNT_CLK_HZ;
    localparam logic [6:0] DIV_LAST = 7'(COUNT_DIV - 1);
    localparam logic [1:0] PRESCALE_LAST = 2'h3;

    ////////////////////////////////////////////////////////////////////////////////
    // controller register map (axi4-lite)
    localparam logic [7:0] H_OFS_CMD = 8'h00;
    localparam logic [7:0] H_OFS_WDATA = 8'h04;
    localparam logic [7:0] H_OFS_RDATA = 8'h08;
    localparam logic [7:0] H_OFS_STATUS = 8'h0C;
    localparam logic [7:0] H_OFS_CLKSEL = 8'h10;
    localparam int CMD_START = 0;
    localparam int CMD_WRITE = 1;
    localparam int CMD_FEED = 2;
    localparam int CMD_TGT_LSB = 8;
    localparam int CMD_TGT_MSB = 15;
    localparam int ST_BUSY = 0;
    localparam int ST_RAN = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic {H_IDLE, H_WAIT} wwdr_host_state_t;

endpackage

// [logic/wwdr_bus_if.sv]
// register access link between controller and watchdog
`timescale 1ns/10ps
interface wwdr_bus_if;
    logic req;
    logic we;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic ack;

    modport device (input req, input we, input addr, input wdata, output rdata, output ack);
    modport host (output req, output we, output addr, output wdata, input rdata, input ack);
endinterface

// [logic/wwdr_host.sv]
// controller: axi4-lite orders turned into watchdog register accesses
`timescale 1ns/10ps
module wwdr_host
    import wwdr_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_n_i,
    wwdr_bus_if.host bus,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic clock_select_o
);

    typedef struct packed {
        wwdr_host_state_t fsm;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] axi_rdata;
        logic aw_got;
        logic w_got;
        logic [7:0] aw_addr;
        logic [31:0] w_data;
        logic [31:0] wdata_reg;
        logic [31:0] result;
        logic busy;
        logic feed2;
        logic ran;
        logic clksel;
        logic req;
        logic we;
        logic [7:0] addr;
        logic [31:0] wdata;
    } wwdr_host_s_t;

    wwdr_host_s_t state_reg;
    wwdr_host_s_t state_next;

    always_comb
    begin
        logic [31:0] data;
        data = '0;
        state_next = state_reg;
        state_next.req = 1'b0;

        ////////////////////////////////////////////////////////////////////////////////
        // axi write: address and data taken in either order
        if (s_axi_awvalid_i && state_reg.awready)
        begin
            state_next.awready = 1'b0;
            state_next.aw_got = 1'b1;
            state_next.aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && state_reg.wready)
        begin
            state_next.wready = 1'b0;
            state_next.w_got = 1'b1;
            state_next.w_data = s_axi_wdata_i;
        end
        if (state_reg.aw_got && state_reg.w_got && !state_reg.bvalid)
        begin
            state_next.bvalid = 1'b1;
            state_next.bresp = RESP_OKAY;
            if (state_reg.aw_addr == H_OFS_CMD)
            begin
                // orders arriving while busy are dropped; status shows busy
                if (state_reg.w_data[CMD_START] && !state_reg.busy)
                begin
                    state_next.busy = 1'b1;
                    state_next.fsm = H_WAIT;
                    state_next.req = 1'b1;
                    if (state_reg.w_data[CMD_FEED])
                    begin
                        state_next.we = 1'b1;
                        state_next.addr = OFS_FEED;
                        state_next.wdata = 32'(FEED_FIRST);
                        state_next.feed2 = 1'b1;
                    end
                    else
                    begin
                        state_next.we = state_reg.w_data[CMD_WRITE];
                        state_next.addr = state_reg.w_data[CMD_TGT_MSB:CMD_TGT_LSB];
                        data = state_reg.wdata_reg;
                        if (state_next.addr == OFS_MODE)
                        begin
                            data = data & MODE_MASK;
                            if (!data[BIT_RST])
                            begin
                                data[BIT_PROT] = 1'b0;
                            end
                            if (state_next.we && data[BIT_RUN])
                            begin
                                state_next.ran = 1'b1;
                            end
                        end
                        state_next.wdata = data;
                    end
                end
            end
            else if (state_reg.aw_addr == H_OFS_WDATA)
            begin
                state_next.wdata_reg = state_reg.w_data;
            end
            else if (state_reg.aw_addr == H_OFS_CLKSEL)
            begin
                if (!state_reg.ran)
                begin
                    state_next.clksel = state_reg.w_data[0];
                end
            end
            else
            begin
                state_next.bresp = RESP_SLVERR;
            end
        end
        if (state_reg.bvalid && s_axi_bready_i)
        begin
            state_next.bvalid = 1'b0;
            state_next.aw_got = 1'b0;
            state_next.w_got = 1'b0;
            state_next.awready = 1'b1;
            state_next.wready = 1'b1;
        end

        ////////////////////////////////////////////////////////////////////////////////
        // axi read
        if (s_axi_arvalid_i && state_reg.arready)
        begin
            state_next.arready = 1'b0;
            state_next.rvalid = 1'b1;
            state_next.rresp = RESP_OKAY;
            state_next.axi_rdata = '0;
            if (s_axi_araddr_i == H_OFS_WDATA)
            begin
                state_next.axi_rdata = state_reg.wdata_reg;
            end
            else if (s_axi_araddr_i == H_OFS_RDATA)
            begin
                state_next.axi_rdata = state_reg.result;
            end
            else if (s_axi_araddr_i == H_OFS_STATUS)
            begin
                state_next.axi_rdata[ST_BUSY] = state_reg.busy;
                state_next.axi_rdata[ST_RAN] = state_reg.ran;
            end
            else if (s_axi_araddr_i == H_OFS_CLKSEL)
            begin
                state_next.axi_rdata[0] = state_reg.clksel;
            end
            else if (s_axi_araddr_i != H_OFS_CMD)
            begin
                state_next.rresp = RESP_SLVERR;
            end
        end
        if (state_reg.rvalid && s_axi_rready_i)
        begin
            state_next.rvalid = 1'b0;
            state_next.arready = 1'b1;
        end

        ////////////////////////////////////////////////////////////////////////////////
        // link engine: wait for ack; a feed sends its second byte right after
        case (state_reg.fsm)
            H_IDLE:
            begin
                state_next.fsm = state_next.fsm;
            end
            H_WAIT:
            begin
                if (bus.ack)
                begin
                    state_next.result = bus.rdata;
                    if (state_reg.feed2)
                    begin
                        state_next.feed2 = 1'b0;
                        state_next.req = 1'b1;
                        state_next.wdata = 32'(FEED_SECOND);
                    end
                    else
                    begin
                        state_next.busy = 1'b0;
                        state_next.fsm = H_IDLE;
                    end
                end
            end
            default:
            begin
                state_next.fsm = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            state_reg <= '0;
            state_reg.fsm <= H_IDLE;
            state_reg.awready <= 1'b1;
            state_reg.wready <= 1'b1;
            state_reg.arready <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign bus.req = state_reg.req;
    assign bus.we = state_reg.we;
    assign bus.addr = state_reg.addr;
    assign bus.wdata = state_reg.wdata;
    assign s_axi_awready_o = state_reg.awready;
    assign s_axi_wready_o = state_reg.wready;
    assign s_axi_bresp_o = state_reg.bresp;
    assign s_axi_bvalid_o = state_reg.bvalid;
    assign s_axi_arready_o = state_reg.arready;
    assign s_axi_rdata_o = state_reg.axi_rdata;
    assign s_axi_rresp_o = state_reg.rresp;
    assign s_axi_rvalid_o = state_reg.rvalid;
    assign clock_select_o = state_reg.clksel;

endmodule

// [dv/wwdr_asserts.sv]
// checker on the link between controller and watchdog
`timescale 1ns/10ps
module wwdr_asserts
    import wwdr_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic req,
    input wire logic we,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [31:0] rdata,
    input wire logic ack,
    input wire logic chip_reset_o,
    input wire logic warning_o,
    input wire logic clock_lock_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    ////////////////////////////////////////////////////////////////////////////////
    AST_ACK_ONE: assert property (req |=> ack)
        else $error("link request not answered next cycle");
    AST_ACK_CAUSE: assert property (ack |-> $past(req))
        else $error("link answer without request");
    AST_FEED_RD_ZERO: assert property (req && !we && addr == OFS_FEED |=> rdata == 32'h0)
        else $error("feed read returned data");
    AST_RELOAD_MIN: assert property (req && !we && addr == OFS_RELOAD
        |=> rdata[23:0] >= RELOAD_MIN)
        else $error("reload below minimum");
    AST_LOCK_STAYS: assert property (clock_lock_o |=> clock_lock_o)
        else $error("run enable cleared");
    // reset pulse only once counting is live, i.e. run enable set
    AST_RESET_NEEDS_LOCK: assert property (chip_reset_o |-> clock_lock_o)
        else $error("chip reset while stopped");
    AST_RESET_PULSE: assert property (chip_reset_o |=> !chip_reset_o)
        else $error("chip reset longer than one cycle");
    AST_WARN_STICKY: assert property (warning_o && !(req && we && addr == OFS_MODE
        && wdata[BIT_WFLAG]) |=> warning_o)
        else $error("warning flag lost without clear");
endmodule

// [dv/testbench.sv]
// self-checking bench: controller and watchdog joined by the link
`timescale 1ns/10ps
module testbench;
    import wwdr_pkg::*;
    logic clock_i = 1'b0, reset_n_i = 1'b0;
    logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
    logic [31:0] s_axi_wdata_i = 32'h0;
    logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_arvalid_i = 1'b0;
    // responses are always accepted at once; legal, since ready may stay high
    logic s_axi_bready_i = 1'b1, s_axi_rready_i = 1'b1;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    logic [31:0] s_axi_rdata_o;
    logic clock_select_o, chip_reset_o, warning_o, clock_lock_o;
    int mismatches = 0, n_compared = 0, resets = 0, cycles = 0;
    wwdr_bus_if link();
    wwdr_host wwdr_host_inst (.*, .bus(link));
    wwdr_device wwdr_device_inst (.*, .bus(link));
    wwdr_asserts wwdr_asserts_inst (.clock_i, .reset_n_i, .req(link.req), .we(link.we),
        .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack),
        .chip_reset_o, .warning_o, .clock_lock_o);
    always #10 clock_i = ~clock_i;
    always @(posedge clock_i)
    begin
        resets <= resets + int'(chip_reset_o === 1'b1);
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            mismatches++;
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        do
        begin
            @(posedge clock_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
        end while ((s_axi_awvalid_i && !s_axi_awready_o) || (s_axi_wvalid_i && !s_axi_wready_o));
        do @(posedge clock_i); while (s_axi_bvalid_o !== 1'b1);
        check("write resp", {30'h0, RESP_OKAY}, {30'h0, s_axi_bresp_o});
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        do @(posedge clock_i); while (s_axi_arready_o !== 1'b1);
        s_axi_arvalid_i <= 1'b0;
        do @(posedge clock_i); while (s_axi_rvalid_o !== 1'b1);
        d = s_axi_rdata_o;
        r = s_axi_rresp_o;
    endtask
    task automatic dev_cmd(input logic [7:0] ofs, input logic [7:0] op);
        logic [31:0] s;
        logic [1:0] r;
        axi_wr(H_OFS_CMD, {16'h0000, ofs, op});
        do axi_rd(H_OFS_STATUS, s, r); while (s[ST_BUSY] !== 1'b0);
    endtask
    task automatic dev_wr(input logic [7:0] ofs, input logic [31:0] d);
        axi_wr(H_OFS_WDATA, d);
        dev_cmd(ofs, 8'h03);
    endtask
    task automatic dev_rd(input logic [7:0] ofs, output logic [31:0] d);
        logic [1:0] r;
        dev_cmd(ofs, 8'h01);
        axi_rd(H_OFS_RDATA, d, r);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [31:0] v;
        logic [1:0] r;
        logic [7:0] ofs [6] = '{OFS_MODE, OFS_RELOAD, OFS_FEED, OFS_COUNT, OFS_WARN, OFS_WINDOW};
        logic [31:0] ex [6] = '{32'h0, 32'hFF, 32'h0, 32'hFF, 32'h0, 32'hFFFFFF};
        for (int i = 0; i < 6; i++)
        begin
            dev_rd(ofs[i], v);
            check("reset value", ex[i], v);
        end
        axi_rd(8'h20, v, r);
        check("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    endtask
    task automatic t_lock;
        logic [31:0] v;
        axi_wr(H_OFS_CLKSEL, 32'h1);
        dev_wr(OFS_RELOAD, 32'h10);
        dev_wr(OFS_WARN, 32'hFB);
        dev_wr(OFS_MODE, 32'h3);
        dev_wr(OFS_MODE, 32'h0);
        axi_wr(H_OFS_CLKSEL, 32'h0);
        check("clock select", 32'h1, clock_select_o);
        check("lock", 32'h1, clock_lock_o);
        dev_rd(OFS_MODE, v);
        check("mode set only", 32'h3, v);
        dev_rd(OFS_RELOAD, v);
        check("reload min", 32'hFF, v);
        dev_wr(OFS_FEED, 32'hAA);
        repeat (900) @(posedge clock_i);
        dev_rd(OFS_MODE, v);
        check("no event before feed", 32'h3, v);
        dev_rd(OFS_COUNT, v);
        check("count idle", 32'hFF, v);
    endtask
    task automatic t_warn;
        logic [31:0] v;
        dev_cmd(OFS_FEED, 8'h05);
        repeat (1000) @(posedge clock_i);
        check("warning early", 32'h0, warning_o);
        // the fifth tick after the feed may land up to 2000 cycles later
        repeat (1000) @(posedge clock_i);
        check("warning", 32'h1, warning_o);
        dev_rd(OFS_COUNT, v);
        check("counting", 32'h1, v < 32'hFF);
        dev_wr(OFS_MODE, 32'h8);
        check("warning clear", 32'h0, warning_o);
    endtask
    task automatic t_events;
        logic [31:0] v;
        int n;
        n = resets;
        dev_wr(OFS_FEED, 32'hAA);
        dev_rd(OFS_WARN, v);
        dev_rd(OFS_MODE, v);
        check("feed error flag", 32'h1, v[BIT_TOF]);
        check("feed error reset", n + 1, resets);
        dev_wr(OFS_MODE, 32'h0);
        dev_rd(OFS_MODE, v);
        check("flag cleared", 32'h0, v[BIT_TOF]);
        dev_wr(OFS_WINDOW, 32'h10);
        dev_cmd(OFS_FEED, 8'h05);
        dev_rd(OFS_MODE, v);
        check("window flag", 32'h1, v[BIT_TOF]);
        check("window reset", n + 2, resets);
        dev_wr(OFS_WINDOW, 32'hFFFFFF);
        dev_wr(OFS_MODE, 32'h13);
        dev_cmd(OFS_FEED, 8'h05);
        dev_wr(OFS_RELOAD, 32'h200);
        dev_rd(OFS_RELOAD, v);
        check("protected reload", 32'hFF, v);
        dev_rd(OFS_MODE, v);
        check("protect mode", 32'h17, v);
        check("protect reset", n + 3, resets);
    endtask
    initial
    begin
        repeat (3) @(posedge clock_i);
        reset_n_i <= 1'b1;
        @(posedge clock_i);
        t_reset();
        t_lock();
        t_warn();
        t_events();
        test_done();
    end
endmodule
